/* hdl/fbsp_pkg.sv */
// shared constants, pin bundles and helpers of the flow-through burst sram port
// assumes one 125 mhz clock shared with the bus master that drives the pins
package fbsp_pkg;

  localparam int ADDR_W = 21;
  localparam int WORDS = 2097152;
  localparam int LANES = 4;
  localparam int LANE_DW = 8;
  localparam int DATA_W = 32;
  localparam int WORD_W = 36;
  localparam int BURST_W = 2;

  // clock and timing figures
  localparam int CLK_PERIOD_PS = 8000;
  localparam int CLOCK_TO_DATA_DELAY_PS = 6500;
  localparam int CLOCK_TO_DATA_DELAY_CYC =
    (CLOCK_TO_DATA_DELAY_PS / CLK_PERIOD_PS < 1) ? 1 : CLOCK_TO_DATA_DELAY_PS / CLK_PERIOD_PS;
  // sleep entry and exit, counted in bus cycles
  localparam int SLEEP_SWITCH_TCYC = 2;
  localparam int SLEEP_SWITCH_CYC = SLEEP_SWITCH_TCYC * CLK_PERIOD_PS / CLK_PERIOD_PS;
  localparam logic [1:0] SLEEP_CNT_LAST = 2'(SLEEP_SWITCH_CYC - 1);

  // reset values, burst step and lane masks
  localparam logic [1:0] SLEEP_CNT_RST = 2'h0;
  localparam logic [1:0] BEAT_RST = 2'h0;
  localparam logic [1:0] BURST_STEP = 2'h1;
  localparam logic [1:0] MODE_SYNC_RST = 2'h3;
  localparam logic [1:0] SLEEP_SYNC_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 21'h00_0000;
  localparam logic [DATA_W-1:0] DOUT_RST = 32'h0000_0000;
  localparam logic [LANES-1:0] POUT_RST = 4'h0;
  localparam logic [LANES-1:0] LANES_ALL = 4'hF;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;

  typedef enum logic [3:0] {
    ST_DESEL = 4'h1,
    ST_READ = 4'h2,
    ST_WRITE = 4'h4,
    ST_SLEEP = 4'h8
  } fbsp_phase_t;

  typedef struct packed {
    logic ce1_n;
    logic ce2;
    logic ce3_n;
  } fbsp_sel_t;

  typedef struct packed {
    logic global_write_n;
    logic byte_write_en_n;
    logic [LANES-1:0] byte_lane_write_n;
  } fbsp_wr_t;

  function automatic logic fbsp_selected(input fbsp_sel_t s);
    return !s.ce1_n && s.ce2 && !s.ce3_n;
  endfunction

  function automatic logic [LANES-1:0] fbsp_lane_mask(input fbsp_wr_t w);
    if (!w.global_write_n) begin
      return LANES_ALL;
    end else if (!w.byte_write_en_n) begin
      return ~w.byte_lane_write_n;
    end
    return LANES_NONE;
  endfunction

  function automatic logic [BURST_W-1:0] fbsp_burst_ofs(input logic [BURST_W-1:0] start,
                                                        input logic [BURST_W-1:0] beat,
                                                        input logic interleave);
    return interleave ? (start ^ beat) : BURST_W'(start + beat);
  endfunction

endpackage

/* hdl/fbsp_burst_ctr.sv */
// two-bit wraparound burst counter of the sram port
// assumes load and step are never high together; the parent enforces this
`timescale 1ns/1ps
module fbsp_burst_ctr import fbsp_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire logic [BURST_W-1:0] start,
  input wire logic step,
  input wire logic interleave,
  output logic [BURST_W-1:0] ofs_next,
  output logic [BURST_W-1:0] ofs_cur
);

  typedef struct packed {
    logic [BURST_W-1:0] start;
    logic [BURST_W-1:0] beat;
  } fbsp_ctr_t;

  fbsp_ctr_t q;
  fbsp_ctr_t d;

  always_comb begin
    d = q;
    if (load) begin
      d.start = start;
      d.beat = BEAT_RST;
    end else if (step) begin
      d.beat = BURST_W'(q.beat + BURST_STEP);
    end
    ofs_next = fbsp_burst_ofs(d.start, d.beat, interleave);
  end

  assign ofs_cur = fbsp_burst_ofs(q.start, q.beat, interleave);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '{start: BEAT_RST, beat: BEAT_RST};
    end else begin
      q <= d;
    end
  end

endmodule

/* hdl/fbsp_sram_port.sv */
// flow-through burst sram port: 2m words of four nine-bit lanes behind a
// synchronous strobe interface with burst counter, byte writes and sleep
// assumes the bus master runs on clk_sys; output enable and sleep are asynchronous
`timescale 1ns/1ps

module fbsp_sram_port import fbsp_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire fbsp_sel_t sel,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_step_n,
  input wire fbsp_wr_t wr,
  input wire logic out_en_n,
  input wire logic sleep_req,
  input wire logic burst_mode,
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic [LANES-1:0] parity_io_i,
  output logic [LANES-1:0] parity_io_o,
  output logic parity_io_oe,
  output logic sleeping
);

  typedef struct packed {
    fbsp_phase_t phase;
    logic [ADDR_W-1:0] addr;
    logic first;
    logic [1:0] sleep_cnt;
    logic [DATA_W-1:0] dout;
    logic [LANES-1:0] pout;
    logic [1:0] mode_sync;
    logic [1:0] sleep_sync;
  } fbsp_state_t;

  fbsp_state_t q;
  fbsp_state_t d;

  logic [WORD_W-1:0] mem [WORDS];

  logic proc_take;
  logic ctrl_take;
  logic awake;
  logic chip_on;
  logic load;
  logic in_burst;
  logic access;
  logic do_write;
  logic step;
  logic [LANES-1:0] wr_mask;
  logic [BURST_W-1:0] ofs_next;
  logic [BURST_W-1:0] ofs_cur;
  logic [ADDR_W-1:0] eff_addr;
  logic [WORD_W-1:0] rd_word;

  // sleep is decided only on the synchronised level, so a pending
  // access may still finish in the two cycles before the port idles
  assign awake = (q.phase != ST_SLEEP) && !q.sleep_sync[1];
  // select one gates the processor strobe
  assign proc_take = !proc_addr_strobe_n && !sel.ce1_n;
  assign ctrl_take = !ctrl_addr_strobe_n && !proc_take;
  assign load = awake && (proc_take || ctrl_take);
  // selects looked at only on load
  assign chip_on = fbsp_selected(sel);
  assign in_burst = (q.phase == ST_READ) || (q.phase == ST_WRITE);
  assign access = awake && (load ? chip_on : in_burst);
  assign do_write = access && (fbsp_lane_mask(wr) != LANES_NONE) && !(load && proc_take);
  assign wr_mask = do_write ? fbsp_lane_mask(wr) : LANES_NONE;
  assign step = awake && !load && in_burst && !burst_step_n;
  assign eff_addr = {(load ? addr[ADDR_W-1:BURST_W] : q.addr[ADDR_W-1:BURST_W]), ofs_next};
  assign rd_word = mem[eff_addr];

  fbsp_burst_ctr u_ctr (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(load),
    .start(addr[BURST_W-1:0]),
    .step(step),
    .interleave(q.mode_sync[1]),
    .ofs_next(ofs_next),
    .ofs_cur(ofs_cur)
  );

  always_comb begin
    d = q;
    d.mode_sync = {q.mode_sync[0], burst_mode};
    d.sleep_sync = {q.sleep_sync[0], sleep_req};
    case (q.phase)
      ST_SLEEP: begin
        if (q.sleep_sync[1]) begin
          d.sleep_cnt = SLEEP_CNT_RST;
        end else if (q.sleep_cnt == SLEEP_CNT_LAST) begin
          d.phase = ST_DESEL;
          d.sleep_cnt = SLEEP_CNT_RST;
        end else begin
          d.sleep_cnt = 2'(q.sleep_cnt + 2'h1);
        end
      end
      ST_DESEL, ST_READ, ST_WRITE: begin
        d.first = 1'b0;
        if (q.sleep_sync[1]) begin
          d.phase = ST_DESEL;
          if (q.sleep_cnt == SLEEP_CNT_LAST) begin
            d.phase = ST_SLEEP;
            d.sleep_cnt = SLEEP_CNT_RST;
          end else begin
            d.sleep_cnt = 2'(q.sleep_cnt + 2'h1);
          end
        end else begin
          d.sleep_cnt = SLEEP_CNT_RST;
          if (load) begin
            d.addr = addr;
            if (!chip_on) begin
              d.phase = ST_DESEL;
            end else begin
              d.phase = do_write ? ST_WRITE : ST_READ;
              d.first = (q.phase == ST_DESEL) && !do_write;
            end
          // no strobe keeps or steps the burst
          end else if (in_burst) begin
            d.phase = do_write ? ST_WRITE : ST_READ;
          end
        end
      end
      default: begin
        d.phase = ST_DESEL;
        d.sleep_cnt = SLEEP_CNT_RST;
      end
    endcase
    // word read straight from the array
    if (access && !do_write) begin
      d.dout = rd_word[DATA_W-1:0];
      d.pout = rd_word[WORD_W-1:DATA_W];
    end
  end

  // all synchronous state on the rising edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '{phase: ST_DESEL, addr: ADDR_RST, first: 1'b0, sleep_cnt: SLEEP_CNT_RST,
             dout: DOUT_RST, pout: POUT_RST, mode_sync: MODE_SYNC_RST,
             sleep_sync: SLEEP_SYNC_RST};
    end else begin
      q <= d;
    end
  end

  // array has no reset; contents survive reset and sleep alike
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < LANES; i++) begin
      if (wr_mask[i]) begin
        // write data taken at the edge
        mem[eff_addr][i*LANE_DW +: LANE_DW] <= dq_i[i*LANE_DW +: LANE_DW];
        // parity bit under its lane select
        mem[eff_addr][DATA_W+i] <= parity_io_i[i];
      end
    end
  end

  // output enable is left asynchronous on purpose: it only gates the
  // pin drivers and never reaches a flop, so no metastability reaches state
  // drive only while output enable low
  assign dq_oe = (q.phase == ST_READ) && !q.first && !out_en_n;
  assign parity_io_oe = dq_oe;
  assign dq_o = q.dout;
  assign parity_io_o = q.pout;
  assign sleeping = (q.phase == ST_SLEEP);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_oe_follows_pin;
    dq_oe |-> !out_en_n && q.phase == ST_READ;
  endproperty
  a_oe_follows_pin: assert property (p_oe_follows_pin) else $error("data driven without read");

  property p_first_read_released;
    (q.phase == ST_DESEL && awake && proc_take && chip_on) |=> !dq_oe && q.phase == ST_READ;
  endproperty
  a_first_read_released: assert property (p_first_read_released) else $error("first read drove");

  property p_proc_wins;
    (awake && proc_take && !ctrl_addr_strobe_n && chip_on && !wr.global_write_n)
      |=> q.phase == ST_READ && q.addr == $past(addr);
  endproperty
  a_proc_wins: assert property (p_proc_wins) else $error("controller strobe not ignored");

  property p_ce1_blocks_proc;
    (in_burst && awake && sel.ce1_n && !proc_addr_strobe_n && ctrl_addr_strobe_n)
      |=> $stable(q.addr);
  endproperty
  a_ce1_blocks_proc: assert property (p_ce1_blocks_proc) else $error("strobe taken");

  property p_deselect;
    (load && !chip_on) |=> q.phase == ST_DESEL ##1 !dq_oe;
  endproperty
  a_deselect: assert property (p_deselect) else $error("deselect not honoured");

  property p_linear_step;
    (step && !q.mode_sync[1]) |=> ofs_cur == 2'($past(ofs_cur) + 2'h1);
  endproperty
  a_linear_step: assert property (p_linear_step) else $error("linear step wrong");

  property p_hold_address;
    (in_burst && awake && !load && burst_step_n) |=> $stable(ofs_cur) && $stable(q.addr);
  endproperty
  a_hold_address: assert property (p_hold_address) else $error("burst address moved");

  property p_global_write;
    (do_write && !wr.global_write_n)
      |=> mem[$past(eff_addr)] == $past({parity_io_i, dq_i});
  endproperty
  a_global_write: assert property (p_global_write) else $error("global write incomplete");

  property p_flow_read;
    (access && !do_write) |=> dq_o == $past(rd_word[DATA_W-1:0]) && parity_io_o == $past(rd_word[WORD_W-1:DATA_W]);
  endproperty
  a_flow_read: assert property (p_flow_read) else $error("read word late");

  property p_sleep_entry;
    (q.sleep_sync[1] && q.phase != ST_SLEEP && q.sleep_cnt == SLEEP_CNT_RST) ##1 q.sleep_sync[1]
      |=> sleeping ##1 !dq_oe;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry not in two cycles");

  property p_sleep_exit;
    (sleeping && !q.sleep_sync[1]) ##1 (sleeping && !q.sleep_sync[1]) |=> q.phase == ST_DESEL;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit not in two cycles");

endmodule

/* testbench/fbsp_master.sv */
// bus master model: drives the access pins of the sram port, one bus cycle per task call
// assumes the bench calls cyc just after any point in time; pins change after the rising edge
`timescale 1ns/1ps
module fbsp_master import fbsp_pkg::*; (
  input wire logic clk_sys,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic dq_oe,
  input wire logic [LANES-1:0] parity_io_o,
  input wire logic parity_io_oe,
  output logic [ADDR_W-1:0] addr,
  output fbsp_sel_t sel,
  output logic proc_addr_strobe_n,
  output logic ctrl_addr_strobe_n,
  output logic burst_step_n,
  output fbsp_wr_t wr,
  output logic out_en_n,
  output logic [DATA_W-1:0] dq_i,
  output logic [LANES-1:0] parity_io_i
);
  logic [WORD_W-1:0] drv_q = 36'h0_0000_0000;
  // device drives when enabled
  // outside writes the bench hands a fresh random word, so a released line never repeats
  assign dq_i = dq_oe ? dq_o : drv_q[DATA_W-1:0];
  assign parity_io_i = parity_io_oe ? parity_io_o : drv_q[WORD_W-1:DATA_W];
  initial begin
    addr = 21'h00_0000;
    sel = '{1'b1, 1'b0, 1'b1};
    proc_addr_strobe_n = 1'b1;
    ctrl_addr_strobe_n = 1'b1;
    burst_step_n = 1'b1;
    wr = '{1'b1, 1'b1, 4'hF};
    out_en_n = 1'b1;
  end
  task automatic cyc(input logic [ADDR_W-1:0] a, input fbsp_sel_t s, input logic p_n,
                     input logic c_n, input logic st_n, input fbsp_wr_t w,
                     input logic [WORD_W-1:0] d, input logic o_n);
    @(posedge clk_sys);
    addr <= a;
    sel <= s;
    proc_addr_strobe_n <= p_n;
    ctrl_addr_strobe_n <= c_n;
    burst_step_n <= st_n;
    wr <= w;
    drv_q <= d;
    out_en_n <= o_n;
  endtask
endmodule

/* testbench/fbsp_sram_port_tb.sv */
// self-checking bench of the flow-through burst sram port
// assumes the master model drives every access pin; reads are checked against a word model
`timescale 1ns/1ps
module fbsp_sram_port_tb import fbsp_pkg::*; ;
  localparam fbsp_sel_t SON = '{1'b0, 1'b1, 1'b0};
  localparam fbsp_sel_t SOFF = '{1'b0, 1'b0, 1'b0};
  localparam fbsp_sel_t SCE1 = '{1'b1, 1'b1, 1'b0};
  localparam fbsp_wr_t WNO = '{1'b1, 1'b1, 4'hF};
  localparam fbsp_wr_t WALL = '{1'b0, 1'b1, 4'hF};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic sleep_req = 1'b0;
  logic burst_mode = 1'b0;
  logic [ADDR_W-1:0] addr;
  fbsp_sel_t sel;
  logic ps_n, cs_n, st_n, oe_n, dq_oe, par_oe, sleeping;
  fbsp_wr_t wr;
  logic [DATA_W-1:0] dq_i, dq_o;
  logic [LANES-1:0] par_i, par_o;
  int fail_count = 0;
  int check_count = 0;
  int seed = 70615;
  logic [WORD_W-1:0] mem [int];
  logic [WORD_W-1:0] expq [$];
  always #4 clk_sys = ~clk_sys;
  fbsp_sram_port dut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .sel(sel),
    .proc_addr_strobe_n(ps_n), .ctrl_addr_strobe_n(cs_n), .burst_step_n(st_n), .wr(wr),
    .out_en_n(oe_n), .sleep_req(sleep_req), .burst_mode(burst_mode), .dq_i(dq_i),
    .dq_o(dq_o), .dq_oe(dq_oe), .parity_io_i(par_i), .parity_io_o(par_o),
    .parity_io_oe(par_oe), .sleeping(sleeping));
  fbsp_master m (.clk_sys(clk_sys), .dq_o(dq_o), .dq_oe(dq_oe), .parity_io_o(par_o),
    .parity_io_oe(par_oe), .addr(addr), .sel(sel), .proc_addr_strobe_n(ps_n),
    .ctrl_addr_strobe_n(cs_n), .burst_step_n(st_n), .wr(wr), .out_en_n(oe_n),
    .dq_i(dq_i), .parity_io_i(par_i));
  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (fail_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  function automatic logic [WORD_W-1:0] rnd();
    return WORD_W'({$random(seed), $random(seed)});
  endfunction
  function automatic logic [1:0] ofs(input logic [1:0] s, input logic [1:0] b);
    return burst_mode ? (s ^ b) : 2'(s + b);
  endfunction
  task automatic desel();
    m.cyc(21'(rnd()), SOFF, 1'b1, 1'b0, 1'b1, WNO, rnd(), 1'b1);
  endtask
  task automatic idle();
    m.cyc(21'(rnd()), SCE1, 1'b1, 1'b1, 1'b1, WNO, rnd(), 1'b1);
  endtask
  task automatic wr_word(input logic [ADDR_W-1:0] a);
    logic [WORD_W-1:0] d;
    d = rnd();
    m.cyc(a, SON, 1'b1, 1'b0, 1'b1, WALL, d, 1'b1);
    mem[a] = d;
  endtask
  task automatic byte_wr(input logic [ADDR_W-1:0] a);
    logic [WORD_W-1:0] d;
    logic [3:0] ln;
    d = rnd();
    ln = 4'(rnd());
    m.cyc(a, SON, 1'b0, 1'b0, 1'b1, WALL, rnd(), 1'b1);
    m.cyc(a, SOFF, 1'b1, 1'b1, 1'b1, '{1'b1, 1'b0, ~ln}, d, 1'b1);
    for (int i = 0; i < LANES; i++) begin
      if (ln[i]) begin
        mem[a][8*i +: 8] = d[8*i +: 8];
        mem[a][DATA_W+i] = d[DATA_W+i];
      end
    end
  endtask
  // proc strobe with ce1 high, inside a burst, loads nothing
  task automatic ignored(input logic [ADDR_W-1:0] a);
    m.cyc(a, SCE1, 1'b0, 1'b1, 1'b1, WNO, rnd(), 1'b1);
    m.cyc(a, SCE1, 1'b1, 1'b1, 1'b0, WNO, rnd(), 1'b1);
  endtask
  task automatic rd_burst(input logic [ADDR_W-1:0] a, input logic by_ctrl);
    logic o;
    logic [1:0] b, pb;
    m.cyc(a, SON, by_ctrl, ~by_ctrl, 1'b1, WNO, rnd(), 1'(rnd()));
    pb = 2'h0;
    for (int i = 0; i < 7; i++) begin
      o = 1'(rnd());
      b = (i < 5) ? 2'(i) : 2'h0;
      // no drive on the first beat
      if (i > 0 && !o) begin
        expq.push_back(mem[{a[20:2], ofs(a[1:0], pb)}]);
      end
      m.cyc(21'(rnd()), fbsp_sel_t'(3'(rnd())), 1'b1, 1'b1, !(i inside {[1:4]}), WNO,
            rnd(), o);
      pb = b;
    end
    desel();
  endtask
  task automatic sleep_cycle();
    int n;
    desel();
    idle();
    @(posedge clk_sys);
    sleep_req <= 1'b1;
    n = 0;
    while (sleeping !== 1'b1 && n < 10) begin
      @(negedge clk_sys);
      n++;
    end
    chk(36'(n inside {[2:6]}), 36'h1);
    repeat (4) @(posedge clk_sys);
    sleep_req <= 1'b0;
    n = 0;
    while (sleeping !== 1'b0 && n < 10) begin
      @(negedge clk_sys);
      n++;
    end
    chk(36'(n inside {[2:6]}), 36'h1);
    idle();
    idle();
  endtask
  // the result shows in the cycle after its edge; look once it has settled
  always @(negedge clk_sys) begin
    if (dq_oe === 1'b1) begin
      if (expq.size() == 0) begin
        chk(36'h1, 36'h0);
      end else begin
        chk({par_o, dq_o}, expq.pop_front());
      end
      chk(36'(par_oe), 36'h1);
    end
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    final_report();
  end
  initial begin
    for (int md = 0; md < 2; md++) begin
      logic [ADDR_W-1:0] ln;
      @(posedge clk_sys);
      rst <= 1'b1;
      burst_mode <= md[0];
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      @(negedge clk_sys);
      chk(36'({sleeping, dq_oe}), 36'h0);
      repeat (4) begin
        ln = 21'(rnd());
        for (int k = 0; k < 4; k++) begin
          wr_word({ln[20:2], 2'(k)});
        end
        byte_wr({ln[20:2], 2'(rnd())});
        ignored({ln[20:2], 2'h0});
        desel();
        rd_burst({ln[20:2], 2'(rnd())}, 1'(rnd()));
      end
      sleep_cycle();
      rd_burst({ln[20:2], 2'(rnd())}, 1'b0);
    end
    repeat (3) @(posedge clk_sys);
    chk(36'(expq.size()), 36'h0);
    final_report();
  end
endmodule
